/* inc/event_irq_map.svh */
// Register offsets, field positions and reset values of the event interrupt block
`ifndef EVENT_IRQ_MAP_SVH
`define EVENT_IRQ_MAP_SVH

`define EVIRQ_ADDR_W        8
`define EVIRQ_NCH           8
`define EVIRQ_ENCLR_OFS     8'h10
`define EVIRQ_ENSET_OFS     8'h14
`define EVIRQ_FLAG_OFS      8'h18
`define EVIRQ_EVD_LSB       8
`define EVIRQ_OVR_LSB       0
`define EVIRQ_EVD_BYTE      1
`define EVIRQ_OVR_BYTE      0
`define EVIRQ_EN_RESET      8'h00
`define EVIRQ_FLAG_RESET    1'b0
`define EVIRQ_SET_DELAY     1

`endif

/* inc/event_irq_pkg.sv */
// Types shared by the event interrupt block
package event_irq_pkg;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_type;

	typedef enum logic [1:0] {
		SEL_NONE  = 2'b00,
		SEL_ENCLR = 2'b01,
		SEL_ENSET = 2'b11,
		SEL_FLAG  = 2'b10
	} reg_sel_type;

endpackage

/* rtl/sticky_flag_cell.sv */
// One sticky interrupt flag with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
`include "event_irq_map.svh"

module sticky_flag_cell (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic set_req,
	input  wire logic clr_req,
	output var  logic flag_r
);

	// A set in the same cycle as a clear wins, so no event is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= `EVIRQ_FLAG_RESET;
		end else if (set_req) begin
			flag_r <= 1'b1;
		end else if (clr_req) begin
			flag_r <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* rtl/event_channel_irq_flags.sv */
// Interrupt enables, sticky flags and AXI4-Lite access for an eight-channel event router
//
// Notes on behaviour
// - Writing one to an event-detected bit of the set register enables it.
// - Writing one to an overrun bit of the set register enables it.
// - Reading set or clear register returns current enables, one means enabled.
// - Event-detected flag is set one bus cycle after a channel event.
// - Interrupt requested when an event-detected flag and its enable are both one.
// - Asynchronous channel paths never set the event-detected flag.
// - Writing one to an event-detected flag bit clears it; zero no effect.
// - Overrun flag is set one cycle after a channel overrun condition.
// - Interrupt requested when an overrun flag and its enable are both one.
// - Asynchronous channel paths never set the overrun flag.
// - Writing one to an overrun flag bit clears it; zero no effect.
// - Writing one to the clear register disables that enable; shared state.
`timescale 1ns/1ps
`default_nettype none
`include "event_irq_map.svh"

module event_channel_irq_flags
	import event_irq_pkg::*;
#(
	parameter int NCH    = `EVIRQ_NCH,
	parameter int ADDR_W = `EVIRQ_ADDR_W
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [NCH-1:0]    event_detected_n,
	input  wire logic [NCH-1:0]    channel_overrun_n,
	input  wire logic [NCH-1:0]    path_async,
	output logic                   irq
);

	// Protection bits are accepted but carry no meaning here
	logic [2:0]        prot_unused;
	assign prot_unused = s_axi_awprot ^ s_axi_arprot;

	// Write channel holding registers
	logic              aw_full_r;
	logic              w_full_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [31:0]       wr_data_r;
	logic [3:0]        wr_strb_r;
	logic              bvalid_r;
	axi_resp_type      bresp_r;

	// Read channel registers
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	axi_resp_type      rresp_r;

	// Block state
	logic [NCH-1:0]    evd_en_r;
	logic [NCH-1:0]    ovr_en_r;
	logic [NCH-1:0]    evd_flag;
	logic [NCH-1:0]    ovr_flag;

	// Derived write controls
	logic              do_write;
	reg_sel_type       wr_sel;
	reg_sel_type       rd_sel;
	logic [NCH-1:0]    evd_wmask;
	logic [NCH-1:0]    ovr_wmask;
	logic [NCH-1:0]    evd_set;
	logic [NCH-1:0]    ovr_set;
	logic [NCH-1:0]    evd_clr;
	logic [NCH-1:0]    ovr_clr;
	logic [2*NCH-1:0]  flag_set;
	logic [2*NCH-1:0]  flag_clr;
	logic [2*NCH-1:0]  flag_vec;

	// Word decode; byte offset bits are ignored so any lane address hits its word
	function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] word;
		word = {addr[ADDR_W-1:2], 2'b00};
		if (word == `EVIRQ_ENCLR_OFS) begin
			decode = SEL_ENCLR;
		end else if (word == `EVIRQ_ENSET_OFS) begin
			decode = SEL_ENSET;
		end else if (word == `EVIRQ_FLAG_OFS) begin
			decode = SEL_FLAG;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	// Address and data are taken in either order and held until the write is done
	assign s_axi_awready = !aw_full_r && !bvalid_r;
	assign s_axi_wready  = !w_full_r && !bvalid_r;
	assign do_write      = aw_full_r && w_full_r && !bvalid_r;
	assign wr_sel        = decode(wr_addr_r);
	assign rd_sel        = decode(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			wr_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_r <= 1'b1;
			wr_addr_r <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r  <= 1'b0;
			wr_data_r <= 32'h0000_0000;
			wr_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_r  <= 1'b1;
			wr_data_r <= s_axi_wdata;
			wr_strb_r <= s_axi_wstrb;
		end else if (do_write) begin
			w_full_r <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer with a slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// Byte lanes gate which half of the write takes effect
	assign evd_wmask = wr_strb_r[`EVIRQ_EVD_BYTE] ? wr_data_r[`EVIRQ_EVD_LSB +: NCH] : '0;
	assign ovr_wmask = wr_strb_r[`EVIRQ_OVR_BYTE] ? wr_data_r[`EVIRQ_OVR_LSB +: NCH] : '0;

	// One enable state shared by the set and clear registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evd_en_r <= `EVIRQ_EN_RESET;
		end else if (do_write && wr_sel == SEL_ENSET) begin
			evd_en_r <= evd_en_r | evd_wmask;
		end else if (do_write && wr_sel == SEL_ENCLR) begin
			evd_en_r <= evd_en_r & ~evd_wmask;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_en_r <= `EVIRQ_EN_RESET;
		end else if (do_write && wr_sel == SEL_ENSET) begin
			ovr_en_r <= ovr_en_r | ovr_wmask;
		end else if (do_write && wr_sel == SEL_ENCLR) begin
			ovr_en_r <= ovr_en_r & ~ovr_wmask;
		end
	end

	// Asynchronous paths bypass the bus clock, so their flags stay dark
	assign evd_set = event_detected_n & ~path_async;
	assign ovr_set = channel_overrun_n & ~path_async;
	assign evd_clr = (do_write && wr_sel == SEL_FLAG) ? evd_wmask : '0;
	assign ovr_clr = (do_write && wr_sel == SEL_FLAG) ? ovr_wmask : '0;

	assign flag_set = {evd_set, ovr_set};
	assign flag_clr = {evd_clr, ovr_clr};

	genvar gi;
	generate
		for (gi = 0; gi < 2 * NCH; gi++) begin : g_flag
			sticky_flag_cell u_cell (
				.aclk    (aclk),
				.aresetn (aresetn),
				.set_req (flag_set[gi]),
				.clr_req (flag_clr[gi]),
				.flag_r  (flag_vec[gi])
			);
		end
	endgenerate

	assign evd_flag = flag_vec[NCH +: NCH];
	assign ovr_flag = flag_vec[0 +: NCH];

	// Combinational request so it follows flags and enables without extra delay
	assign irq = |(evd_flag & evd_en_r) | |(ovr_flag & ovr_en_r);

	// Read path; one read at a time, answered the cycle after the address is taken
	assign s_axi_arready = !rvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= RESP_OKAY;
			unique case (rd_sel)
				SEL_ENCLR, SEL_ENSET: begin
					rdata_r <= {16'h0000, evd_en_r, ovr_en_r};
				end
				SEL_FLAG: begin
					rdata_r <= {16'h0000, evd_flag, ovr_flag};
				end
				SEL_NONE: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	// Checks kept beside the logic they watch

	enset_evd_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		do_write && wr_sel == SEL_ENSET
		|=> ((evd_en_r & $past(evd_wmask)) == $past(evd_wmask))
			&& ((evd_en_r & ~$past(evd_wmask)) == ($past(evd_en_r) & ~$past(evd_wmask))))
		else $error("event-detected enable not set by write");

	enset_ovr_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		do_write && wr_sel == SEL_ENSET
		|=> ((ovr_en_r & $past(ovr_wmask)) == $past(ovr_wmask))
			&& ((ovr_en_r & ~$past(ovr_wmask)) == ($past(ovr_en_r) & ~$past(ovr_wmask))))
		else $error("overrun enable not set by write");

	read_enable_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && (rd_sel == SEL_ENSET || rd_sel == SEL_ENCLR)
		|=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(evd_en_r), $past(ovr_en_r)})
		else $error("enable read returned wrong state");

	evd_set_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(|evd_set) |=> ((evd_flag & $past(evd_set)) == $past(evd_set)))
		else $error("event-detected flag missed a channel event");

	evd_irq_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(|(evd_flag & evd_en_r)) |-> irq)
		else $error("enabled event-detected flag without request");

	evd_async_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		##1 ((evd_flag & ~$past(evd_flag) & $past(path_async)) == '0))
		else $error("event-detected flag set on asynchronous path");

	evd_clear_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(|evd_clr) ##1 (|($past(evd_clr) & ~$past(evd_set) & evd_flag))[*1] |-> 1'b0)
		else $error("event-detected flag survived a clear");

	ovr_set_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(|ovr_set) |-> ##`EVIRQ_SET_DELAY ((ovr_flag & $past(ovr_set)) == $past(ovr_set)))
		else $error("overrun flag missed a condition");

	ovr_irq_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(|(ovr_flag & ovr_en_r)) |-> irq)
		else $error("enabled overrun flag without request");

	ovr_async_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$changed(ovr_flag) |-> ((ovr_flag & ~$past(ovr_flag) & $past(path_async)) == '0))
		else $error("overrun flag set on asynchronous path");

	ovr_clear_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(|ovr_clr) |=> ((ovr_flag & $past(ovr_clr) & ~$past(ovr_set)) == '0)
			&& ((ovr_flag & ~$past(ovr_clr)) == ($past(ovr_flag | ovr_set) & ~$past(ovr_clr))))
		else $error("overrun flag clear misbehaved");

	enclr_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		do_write && wr_sel == SEL_ENCLR
		|=> ((evd_en_r & $past(evd_wmask)) == '0) && ((ovr_en_r & $past(ovr_wmask)) == '0)
			&& (evd_en_r == ($past(evd_en_r) & ~$past(evd_wmask))))
		else $error("enable clear write misbehaved");

	irq_or_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		irq == ((|(evd_flag & evd_en_r)) || (|(ovr_flag & ovr_en_r))))
		else $error("request does not match enabled flags");

	flag_hold_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(evd_flag != '0) && !do_write |=> ((evd_flag & $past(evd_flag)) == $past(evd_flag)))
		else $error("event-detected flag dropped without a clear");

endmodule
`default_nettype wire

/* tb/event_path_model.sv */
// Model of the event channels that feed the interrupt flag block
`timescale 1ns/1ps
`default_nettype none

module event_path_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] ev_req,
	input  wire logic [7:0] ov_req,
	input  wire logic [7:0] async_req,
	output var  logic [7:0] event_detected_n,
	output var  logic [7:0] channel_overrun_n,
	output var  logic [7:0] path_async
);
	// Registered so every event lasts whole bus cycles, one for each cycle its request is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_detected_n  <= 8'h00;
			channel_overrun_n <= 8'h00;
			path_async        <= 8'h00;
		end else begin
			event_detected_n  <= ev_req;
			channel_overrun_n <= ov_req;
			path_async        <= async_req;
		end
	end
endmodule

`default_nettype wire

/* tb/event_channel_irq_flags_bench.sv */
// Self-checking bench for the event interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`include "event_irq_map.svh"

module event_channel_irq_flags_bench
	import event_irq_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bvalid, bready;
	logic        arvalid, rvalid, rready, awready, wready, arready, irq;
	logic [7:0]  awaddr, araddr, ev_req, ov_req, as_req, evd, ovr, pas;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [15:0] en, fl;
	int          n_fail, compares;

	always #2 aclk = ~aclk;

	event_channel_irq_flags event_channel_irq_flags_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .event_detected_n(evd), .channel_overrun_n(ovr),
		.path_async(pas), .irq(irq)
	);

	event_path_model event_path_model_i (
		.aclk(aclk), .aresetn(aresetn), .ev_req(ev_req), .ov_req(ov_req),
		.async_req(as_req), .event_detected_n(evd), .channel_overrun_n(ovr),
		.path_async(pas)
	);

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_irq(input logic e);
		compares++;
		if (irq !== e) begin
			n_fail++;
			$display("unexpected irq expected %b seen %b", e, irq);
		end
	endtask

	task automatic hang;
		n_fail++;
		$display("unexpected bus wait expected response seen none");
		test_done();
	endtask

	// Address and data are offered together and each released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (i == 64) hang();
	endtask

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int i;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (i == 64) hang();
		chk(n, e, rdata);
		chk("read_resp", {30'h0, er}, {30'h0, rresp});
	endtask

	initial begin
		int          k;
		logic [15:0] w;
		logic [15:0] c;
		logic [7:0]  ev;
		logic [7:0]  ov;
		logic [7:0]  asy;
		logic [1:0]  r;
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, ev_req, ov_req, as_req} = 40'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		n_fail = 0;
		compares = 0;
		en = 16'h0;
		fl = 16'h0;
		void'($urandom(63));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rdc("enable_set", `EVIRQ_ENSET_OFS, 32'h0, RESP_OKAY);
		rdc("enable_clear", `EVIRQ_ENCLR_OFS, 32'h0, RESP_OKAY);
		rdc("flags", `EVIRQ_FLAG_OFS, 32'h0, RESP_OKAY);
		$display("test reset_values finished");
		for (k = 0; k < 8; k++) begin
			w = (k == 0) ? 16'hffff : 16'($urandom);
			c = (k == 0) ? 16'h0000 : 16'($urandom);
			axw(`EVIRQ_ENSET_OFS, {16'h0, w}, r);
			en = en | w;
			chk("write_resp", {30'h0, RESP_OKAY}, {30'h0, r});
			rdc("enable_set", `EVIRQ_ENSET_OFS, {16'h0, en}, RESP_OKAY);
			axw(`EVIRQ_ENCLR_OFS, {16'h0, c}, r);
			en = en & ~c;
			rdc("enable_clear", `EVIRQ_ENCLR_OFS, {16'h0, en}, RESP_OKAY);
		end
		$display("test enables finished");
		// Byte lanes: only the strobed half of a word takes effect
		wstrb <= 4'h2;
		axw(`EVIRQ_ENCLR_OFS, 32'h0000_ffff, r);
		en = en & 16'h00ff;
		rdc("enable_clear", `EVIRQ_ENCLR_OFS, {16'h0, en}, RESP_OKAY);
		wstrb <= 4'h1;
		axw(`EVIRQ_ENSET_OFS, 32'h0000_ffff, r);
		en = en | 16'h00ff;
		rdc("enable_set", `EVIRQ_ENSET_OFS, {16'h0, en}, RESP_OKAY);
		wstrb <= 4'h2;
		axw(`EVIRQ_ENSET_OFS, 32'h0000_5a5a, r);
		wstrb <= 4'hf;
		en = en | 16'h5a00;
		rdc("enable_set", `EVIRQ_ENSET_OFS, {16'h0, en}, RESP_OKAY);
		$display("test byte_lanes finished");
		// First rounds keep all paths synchronous, then all asynchronous, then mixed
		for (k = 0; k < 12; k++) begin
			ev = 8'($urandom);
			ov = 8'($urandom);
			asy = (k < 2) ? 8'h00 : ((k == 2) ? 8'hff : 8'($urandom));
			@(posedge aclk);
			ev_req <= ev;
			ov_req <= ov;
			as_req <= asy;
			@(posedge aclk);
			ev_req <= 8'h00;
			ov_req <= 8'h00;
			@(posedge aclk);
			#1;
			fl = fl | {ev & ~asy, ov & ~asy};
			chk_irq(|(fl & en));
			rdc("flags", `EVIRQ_FLAG_OFS, {16'h0, fl}, RESP_OKAY);
			c = 16'($urandom);
			axw(`EVIRQ_FLAG_OFS, {16'h0, c}, r);
			fl = fl & ~c;
			rdc("flags", `EVIRQ_FLAG_OFS, {16'h0, fl}, RESP_OKAY);
			chk_irq(|(fl & en));
		end
		$display("test flags finished");
		// An event in the cycle of its clear must win, or it would be lost
		fork
			axw(`EVIRQ_FLAG_OFS, 32'h0000_0101, r);
			begin
				@(posedge aclk);
				ev_req <= 8'h01;
				as_req <= 8'h00;
				@(posedge aclk);
				ev_req <= 8'h00;
			end
		join
		fl = (fl & ~16'h0101) | 16'h0100;
		rdc("flags", `EVIRQ_FLAG_OFS, {16'h0, fl}, RESP_OKAY);
		chk_irq(|(fl & en));
		$display("test set_beats_clear finished");
		// Reset in mid-run clears enables and flags alike
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		en = 16'h0;
		fl = 16'h0;
		chk_irq(1'b0);
		rdc("flags", `EVIRQ_FLAG_OFS, 32'h0, RESP_OKAY);
		rdc("enable_clear", `EVIRQ_ENCLR_OFS, 32'h0, RESP_OKAY);
		$display("test mid_reset finished");
		axw(8'h20, 32'hffffffff, r);
		chk("write_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		rdc("unmapped", 8'h20, 32'h0, RESP_SLVERR);
		rdc("enable_set", `EVIRQ_ENSET_OFS, {16'h0, en}, RESP_OKAY);
		$display("test unmapped finished");
		test_done();
	end
endmodule

`default_nettype wire
